//--- logic/tpec_defines.svh
/*
 * constants for the two-phase event counter: widths, reset values, count limits.
 * assumes it is included by bare name from the package and the modules.
 */
`ifndef TPEC_DEFINES_SVH
`define TPEC_DEFINES_SVH

`define TPEC_CNT_W        16
`define TPEC_CNT_RST      16'h0000
`define TPEC_RELOAD_RST   16'h0000
`define TPEC_CNT_MAX      16'hffff
`define TPEC_CNT_MIN      16'h0000
`define TPEC_SYNC_RST     2'h0
`define TPEC_FILT_RST     2'h0

`endif

//--- logic/tpec_pkg.sv
/*
 * types shared by the two-phase event counter modules.
 * assumes tpec_defines.svh is on the include path.
 */
`include "tpec_defines.svh"

package tpec_pkg;

    typedef logic [`TPEC_CNT_W-1:0] tpec_cnt_t;

    // channel personality: fixes which decoders may be chosen
    typedef enum logic [1:0]
    {
        TPEC_CH_TWO   = 2'h0,
        TPEC_CH_THREE = 2'h1,
        TPEC_CH_FOUR  = 2'h2
    } tpec_chan_e;

    // direction of one decoded count step
    typedef enum logic [2:0]
    {
        TPEC_STEP_NONE = 3'h1,
        TPEC_STEP_UP   = 3'h2,
        TPEC_STEP_DOWN = 3'h4
    } tpec_step_e;

endpackage : tpec_pkg

//--- logic/tpec_phase_decode.sv
/*
 * pin synchroniser and two-phase decoder for one counter channel.
 * assumes the pins are asynchronous to mclk and change slower than mclk.
 */
`timescale 1ns/1ns
`include "tpec_defines.svh"

module tpec_phase_decode
    import tpec_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       phase_count_pin,
    input  wire logic       phase_reference_pin,
    input  wire logic       mul4_sel,
    output tpec_step_e      step
);

    logic [1:0] meta_q;
    logic [1:0] meta_d;
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    logic [1:0] prev_q;
    logic [1:0] prev_d;
    tpec_step_e step_c;

    // ************************************************
    // synchronise both pins, remember last sampled pair
    // ************************************************
    always_comb
    begin
        meta_d = {phase_reference_pin, phase_count_pin};
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= `TPEC_SYNC_RST;
            sync_q <= `TPEC_SYNC_RST;
            prev_q <= `TPEC_FILT_RST;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ************************************************
    // decode edges; bit0 is the counting phase (a), bit1 the reference (b)
    // ************************************************
    always_comb
    begin
        step_c = TPEC_STEP_NONE;
        if (mul4_sel)
        begin
            // every edge of either phase; a leading b counts up
            if (sync_q[0] != prev_q[0] && sync_q[1] == prev_q[1])
                step_c = (sync_q[0] != sync_q[1]) ? TPEC_STEP_UP : TPEC_STEP_DOWN;
            else if (sync_q[1] != prev_q[1] && sync_q[0] == prev_q[0])
                step_c = (sync_q[0] == sync_q[1]) ? TPEC_STEP_UP : TPEC_STEP_DOWN;
            // both changing at once is an illegal jump and is ignored
        end
        else if (sync_q[1] && prev_q[1])
        begin
            // reference high: rising a counts up, falling a counts down
            if (sync_q[0] && !prev_q[0])
                step_c = TPEC_STEP_UP;
            else if (!sync_q[0] && prev_q[0])
                step_c = TPEC_STEP_DOWN;
        end
    end

    assign step = step_c;

endmodule : tpec_phase_decode

//--- logic/tpec_counter.sv
/*
 * two-phase event counter channel: 16-bit up/down counter with reload
 * holding register, start flag, read-back and overflow/underflow request.
 * assumes the cpu side drives wr_stb/wr_data, start and mode on mclk.
 */
`timescale 1ns/1ns
`include "tpec_defines.svh"


module tpec_counter
    import tpec_pkg::*;
#(
    parameter tpec_chan_e CHANNEL = TPEC_CH_THREE
)
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       phase_count_pin,
    input  wire logic       phase_reference_pin,
    input  wire logic       count_start,
    input  wire logic       mul4_mode,
    input  wire logic       wr_stb,
    input  wire tpec_cnt_t  wr_data,
    output tpec_cnt_t       count_value,
    output tpec_cnt_t       reload_value,
    output logic            irq_req
);

    tpec_cnt_t  cnt_q;
    tpec_cnt_t  cnt_d;
    tpec_cnt_t  rld_q;
    tpec_cnt_t  rld_d;
    logic       irq_q;
    logic       irq_d;
    logic       mul4_sel;
    tpec_step_e step;

    // ************************************************
    // decoder choice per channel
    // ************************************************
    // the mode input only matters on channel three; others are strapped
    always_comb
    begin
        unique case (CHANNEL)
            TPEC_CH_TWO:   mul4_sel = 1'b0;
            TPEC_CH_FOUR:  mul4_sel = 1'b1;
            default:       mul4_sel = mul4_mode;
        endcase
    end

    tpec_phase_decode u_decode
    (
        .mclk                (mclk),
        .rst_n               (rst_n),
        .phase_count_pin     (phase_count_pin),
        .phase_reference_pin (phase_reference_pin),
        .mul4_sel            (mul4_sel),
        .step                (step)
    );

    // ************************************************
    // counter, reload register and request
    // ************************************************
    // a write in the same cycle as a wrap: the wrap reloads the new value
    always_comb
    begin
        cnt_d = cnt_q;
        rld_d = rld_q;
        irq_d = 1'b0;
        if (wr_stb)
            rld_d = wr_data;
        if (count_start)
        begin
            if (step == TPEC_STEP_UP)
            begin
                if (cnt_q == `TPEC_CNT_MAX)
                begin
                    cnt_d = rld_d;
                    irq_d = 1'b1;
                end
                else
                    cnt_d = cnt_q + 16'h0001;
            end
            else if (step == TPEC_STEP_DOWN)
            begin
                if (cnt_q == `TPEC_CNT_MIN)
                begin
                    cnt_d = rld_d;
                    irq_d = 1'b1;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
        end
        else if (wr_stb)
            cnt_d = wr_data;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= `TPEC_CNT_RST;
            rld_q <= `TPEC_RELOAD_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            rld_q <= rld_d;
            irq_q <= irq_d;
        end
    end

    assign count_value  = cnt_q;
    assign reload_value = rld_q;
    assign irq_req      = irq_q;

    // ************************************************
    // helpers
    // ************************************************
    // one step past either end of the range; shared by the wrap checks so the
    // request and the no-request checks agree on where the ends are
    function automatic logic will_wrap(tpec_step_e s, tpec_cnt_t c);
        return (s == TPEC_STEP_UP && c == `TPEC_CNT_MAX)
            || (s == TPEC_STEP_DOWN && c == `TPEC_CNT_MIN);
    endfunction : will_wrap

    // ************************************************
    // checks
    // ************************************************
    hold_stopped_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (!count_start && !wr_stb) |=> cnt_q == $past(cnt_q))
        else $error("count moved while stopped");

    load_stopped_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (!count_start && wr_stb) |=> (cnt_q == $past(wr_data) && rld_q == cnt_q))
        else $error("stopped write did not load both");

    run_write_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (count_start && wr_stb && step == TPEC_STEP_NONE)
        |=> (rld_q == $past(wr_data) && cnt_q == $past(cnt_q)))
        else $error("running write touched counter");

    up_count_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (count_start && step == TPEC_STEP_UP && cnt_q != `TPEC_CNT_MAX)
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("up step not counted");

    down_count_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (count_start && step == TPEC_STEP_DOWN && cnt_q != `TPEC_CNT_MIN)
        |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("down step not counted");

    wrap_irq_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (count_start && will_wrap(step, cnt_q))
        |=> (irq_req && cnt_q == $past(rld_d)))
        else $error("wrap without request or reload");

    irq_cause_a : assert property (@(posedge mclk) disable iff (!rst_n)
        irq_req |-> $past(count_start) && $past(step) != TPEC_STEP_NONE)
        else $error("request without wrap");

    mode_fixed_a : assert property (@(posedge mclk) disable iff (!rst_n)
        mul4_sel == ((CHANNEL == TPEC_CH_FOUR) ||
                     (CHANNEL == TPEC_CH_THREE && mul4_mode)))
        else $error("decoder choice wrong for channel");

    normal_up_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (!mul4_sel && step == TPEC_STEP_UP) |-> $past(phase_reference_pin, 3))
        else $error("normal count with reference low");

    // pin checks look back two samples for the sync stage, three for the pair before
    no_wrap_irq_a : assert property (@(posedge mclk) disable iff (!rst_n)
        !(count_start && will_wrap(step, cnt_q)) |=> !irq_req)
        else $error("request raised without a wrap");

    normal_rise_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (!mul4_sel && step == TPEC_STEP_UP)
        |-> ($past(phase_count_pin, 2) && !$past(phase_count_pin, 3)
             && $past(phase_reference_pin, 2)))
        else $error("normal up without a rising count pin");

    normal_fall_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (!mul4_sel && step == TPEC_STEP_DOWN)
        |-> (!$past(phase_count_pin, 2) && $past(phase_count_pin, 3)
             && $past(phase_reference_pin, 2) && $past(phase_reference_pin, 3)))
        else $error("normal down without a falling count pin");

    // a up means a moved to differ from b, or b moved to match a
    quad_up_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (mul4_sel && step == TPEC_STEP_UP)
        |-> (($past(phase_count_pin, 2) != $past(phase_count_pin, 3)
              && $past(phase_count_pin, 2) != $past(phase_reference_pin, 2))
          || ($past(phase_reference_pin, 2) != $past(phase_reference_pin, 3)
              && $past(phase_count_pin, 2) == $past(phase_reference_pin, 2))))
        else $error("quadrature up against phase order");

    // only a write may move the reload register, running or not
    reload_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
        !wr_stb |=> rld_q == $past(rld_q))
        else $error("reload register moved without a write");

    stopped_quiet_a : assert property (@(posedge mclk) disable iff (!rst_n)
        !count_start |=> !irq_req)
        else $error("request while stopped");

    idle_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
        (step == TPEC_STEP_NONE && !wr_stb) |=> cnt_q == $past(cnt_q))
        else $error("count moved without a step");

endmodule : tpec_counter

//--- test/tpec_enc_model.sv
/*
 * quadrature pulse source standing in for the encoder on both pins.
 * assumes step requests come several mclk cycles apart.
 */
`timescale 1ns/1ns
module tpec_enc_model
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic step,
    input  wire logic fwd,
    output logic      pin_a,
    output logic      pin_b
);
    logic [1:0] pos_q;
    logic [1:0] pos_d;
    // one gray step per request; forward means pin a leads pin b
    always_comb
    begin
        pos_d = pos_q;
        if (step)
            pos_d = fwd ? pos_q + 2'h1 : pos_q - 2'h1;
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pos_q <= 2'h0;
        else
            pos_q <= pos_d;
    end
    // only one pin moves per step, so no sample ever sees both change
    assign pin_a = pos_q[0] ^ pos_q[1];
    assign pin_b = pos_q[1];
endmodule : tpec_enc_model

//--- test/tpec_counter_test.sv
/*
 * bench for all three counter channels sharing one quadrature source.
 * assumes the model pins move one step per request.
 */
`timescale 1ns/1ns
module tpec_counter_test;
    import tpec_pkg::*;
    typedef struct packed {tpec_cnt_t w; logic m; logic f; int n; tpec_cnt_t e3;} tpec_row_s;
    logic      mclk = 0, rst_n = 0, start = 0, mul4 = 0, wr = 0, step = 0, fwd = 0;
    tpec_cnt_t wdat = 16'h0000, exp_r = 16'h0000;
    wire       pa, pb;
    tpec_cnt_t cnt [3], rld [3], exp_c [3] = '{default: 16'h0000};
    logic      irq [3];
    int        irqn [3] = '{default: 0}, exp_i [3] = '{default: 0};
    int        errors = 0, comparisons = 0, cyc = 0;
    // write, mode and direction per row; last field is the channel three count
    tpec_row_s rows [3] = '{'{16'hfffe, 1, 1, 3, 16'hffff},
                           '{16'h0001, 0, 0, 4, 16'h0002},
                           '{16'h0000, 1, 0, 1, 16'h0000}};
    always #5 mclk = ~mclk;
    tpec_enc_model tpec_enc_model_i (.mclk(mclk), .rst_n(rst_n), .step(step), .fwd(fwd),
                                     .pin_a(pa), .pin_b(pb));
    for (genvar g = 0; g < 3; g++)
    begin : ch
        tpec_counter #(.CHANNEL(tpec_chan_e'(g))) tpec_counter_i (.mclk(mclk),
            .rst_n(rst_n), .phase_count_pin(pa), .phase_reference_pin(pb),
            .count_start(start), .mul4_mode(mul4), .wr_stb(wr), .wr_data(wdat),
            .count_value(cnt[g]), .reload_value(rld[g]), .irq_req(irq[g]));
        // request is a one-cycle pulse, so count it at every edge
        always @(posedge mclk)
            if (irq[g] === 1'b1)
                irqn[g]++;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end
    task automatic chk(tpec_cnt_t got, tpec_cnt_t want);
        comparisons++;
        if (got !== want)
        begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic chkall();
        @(posedge mclk);
        #1;
        for (int g = 0; g < 3; g++)
        begin
            chk(cnt[g], exp_c[g]);
            chk(rld[g], exp_r);
            chk(tpec_cnt_t'(irqn[g]), tpec_cnt_t'(exp_i[g]));
        end
    endtask : chkall
    task automatic wr_word(tpec_cnt_t d);
        @(posedge mclk);
        wr <= 1'b1;
        wdat <= d;
        @(posedge mclk);
        wr <= 1'b0;
        exp_r = d;
        if (!start)
            exp_c = '{d, d, d};
    endtask : wr_word
    // expected step per channel: normal needs reference high, mul4 counts every edge
    function automatic int dl(logic [1:0] o, logic [1:0] n, logic m);
        if (m)
            return ((o[1] != n[1]) == (n[1] != n[0])) ? 1 : -1;
        return (o[1] != n[1] && n[0]) ? (n[1] ? 1 : -1) : 0;
    endfunction : dl
    task automatic go(logic f);
        logic [1:0] o;
        int         d;
        o = {pa, pb};
        @(posedge mclk);
        step <= 1'b1;
        fwd <= f;
        @(posedge mclk);
        step <= 1'b0;
        repeat (7) @(posedge mclk);
        for (int g = 0; g < 3 && start; g++)
        begin
            d = dl(o, {pa, pb}, g == 2 || (g == 1 && mul4));
            if (d == 1)
            begin
                if (exp_c[g] == 16'hffff)
                begin
                    exp_c[g] = exp_r;
                    exp_i[g]++;
                end
                else
                    exp_c[g]++;
            end
            else if (d == -1)
            begin
                if (exp_c[g] == 16'h0000)
                begin
                    exp_c[g] = exp_r;
                    exp_i[g]++;
                end
                else
                    exp_c[g]--;
            end
        end
    endtask : go
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (6) @(posedge mclk);
        chkall();
        @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge mclk);
            start <= 1'b0;
            mul4 <= rows[i].m;
            wr_word(rows[i].w);
            @(posedge mclk);
            start <= 1'b1;
            repeat (rows[i].n) go(rows[i].f);
            chkall();
            chk(cnt[1], rows[i].e3);
        end
        // running write touches reload only; next wrap picks it up
        wr_word(16'h1234);
        chkall();
        go(1'b0);
        go(1'b0);
        chkall();
        @(posedge mclk);
        start <= 1'b0;
        go(1'b1);
        go(1'b1);
        chkall();
        // mid-run reset clears every channel; the first step after it counts once on channels three and four, not on channel two
        wr_word(16'h5a5a);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        start <= 1'b1;
        exp_c = '{default: 16'h0000};
        exp_r = 16'h0000;
        chkall();
        go(1'b1);
        chkall();
        close_out();
    end
endmodule : tpec_counter_test
